// *** core/tape_pkg.sv ***
// Shared constants and types of the tape formatter and its controller
package tape_pkg;
   // Function codes (octal 71, 77, 51, 57, 61)
   localparam logic [5:0] FN_RD_FWD = 6'h39;
   localparam logic [5:0] FN_RD_REV = 6'h3F;
   localparam logic [5:0] FN_WCHK_FWD = 6'h29;
   localparam logic [5:0] FN_WCHK_REV = 6'h2F;
   localparam logic [5:0] FN_WRITE = 6'h31;
   // Density code that selects phase encoding
   localparam logic [2:0] DEN_PE = 3'h4;
   localparam logic [6:0] PRE_ZEROS = 7'h28;
   localparam logic [8:0] CHAR_ONES = 9'h1FF;
   localparam logic [7:0] CRC_POLY = 8'h1D;
   localparam logic [15:0] WORD_CHARS = 16'h0002;
   localparam int ERR_CRC = 0;
   localparam int ERR_LRC = 1;
   localparam int ERR_SEQ = 2;
   // Controller register offsets
   localparam logic [7:0] OFS_CS1 = 8'h00;
   localparam logic [7:0] OFS_CS2 = 8'h04;
   localparam logic [7:0] OFS_TC = 8'h08;
   localparam logic [7:0] OFS_FC = 8'h0C;
   localparam logic [7:0] OFS_DATA = 8'h10;
   // Field positions
   localparam int CS1_IE_BIT = 6;
   localparam int CS1_DONE_BIT = 7;
   localparam int CS1_RUN_BIT = 8;
   localparam int CS2_OCC_BIT = 0;
   localparam int CS2_EBL_BIT = 1;
   localparam int CS2_DRY_BIT = 2;
   localparam int CS2_ERR_LSB = 3;
   localparam int CS2_WREQ_BIT = 6;
   localparam int CS2_TXF_BIT = 7;
   localparam int CS2_RXF_BIT = 8;
   localparam int CS2_CHK_LSB = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RUN_WAIT = 3'h1,
      ST_XFER = 3'h3,
      ST_TAIL = 3'h2,
      ST_GAP = 3'h6
   } fmt_state_e;

   typedef enum logic [1:0] {
      PH_SKIP = 2'h0,
      PH_CRC = 2'h1,
      PH_DATA = 2'h3,
      PH_LRC = 2'h2
   } rd_phase_e;
endpackage

// *** core/tape_link_if.sv ***
// Drive bus between the tape formatter and its controller
`timescale 1ns/1ps
interface tape_link_if;
   logic fn_wr;
   logic [5:0] fn_code;
   logic tc_wr;
   logic [5:0] tc_data;
   logic fc_wr;
   logic [15:0] fc_data;
   logic run;
   logic bus_occupied;
   logic end_of_block;
   logic drive_ready;
   logic [2:0] err;
   logic [7:0] check;
   logic [17:0] r_data;
   logic r_avail;
   logic r_take;
   logic [17:0] w_data;
   logic w_avail;
   logic w_take;
   logic w_req;
   modport fmt(input fn_wr, fn_code, tc_wr, tc_data, fc_wr, fc_data, run,
      r_take, w_data, w_avail, output bus_occupied, end_of_block, drive_ready, err, check, r_data,
      r_avail, w_take, w_req);
   modport ctl(output fn_wr, fn_code, tc_wr, tc_data, fc_wr, fc_data, run,
      r_take, w_data, w_avail, input bus_occupied, end_of_block, drive_ready, err, check, r_data,
      r_avail, w_take, w_req);
endinterface

// *** core/tape_formatter.sv ***
// Tape formatter: function decode, read assembly, write disassembly
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Read codes 71,77,51,57 then run asserted
// - Drive slave select and density onto bus
// - Read function raises forward or reverse line
// - Occupied only after error-free function decode
// - Start pulse once bus held, tape moves
// - Strobe read characters, build LRC and CRC
// - Pack characters into 18-bit words, controller strobes
// - Zero character ends read record data
// - Forward read checks CRC then LRC
// - Reverse read skips LRC, stores CRC, no CRC/LRC errors
// - End-of-block after checks; gap ends block
// - Frame count loaded, code 61 raises forward+write
// - Controller preloads negated character count
// - Run with first word; start pulse, latch
// - Write clock; PE preamble forty zeros, ones
// - Request next words until all transferred
// - PE character: count, parity, phase encode
// - PE overflow writes postamble, end-of-block
// - Read-after-write end: ready, stop, block off
// - NRZ splits on write clock, count, parity, CRC
// - NRZ overflow: end-of-block, then CRC, LRC
// - Controller ready on block end, IE interrupt
module tape_formatter
   import tape_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   tape_link_if.fmt link,
   output logic [2:0] slave_sel_o,
   output logic [2:0] density_select_bits_o,
   output logic forward_motion_line_o,
   output logic reverse_motion_line_o,
   output logic write_line_o,
   output logic slave_start_o,
   output logic [8:0] wr_char_o,
   input wire logic [8:0] rd_char_i,
   input wire logic rd_strobe_i,
   input wire logic transport_write_clock_i,
   input wire logic gap_detect_i
);
   typedef struct packed {
      fmt_state_e st;
      rd_phase_e ph;
      logic [5:0] tc;
      logic [15:0] fc;
      logic [15:0] fetch;
      logic fwd;
      logic rev;
      logic wrt;
      logic start;
      logic bus_occupied;
      logic end_of_block;
      logic [2:0] err;
      logic [7:0] chk;
      logic [7:0] crc;
      logic [7:0] lrc;
      logic [7:0] asm_c;
      logic half;
      logic [17:0] rword;
      logic ravail;
      logic [15:0] cur;
      logic [15:0] nxt;
      logic nfull;
      logic wtake;
      logic [6:0] cnt;
      logic [8:0] wchar;
      logic [2:0] wclk_s;
      logic [2:0] rds_s;
      logic [2:0] gap_s;
      logic [8:0] rch_s1;
      logic [8:0] rch_s2;
   } fmt_s;

   fmt_s r_reg;
   fmt_s r_next;

   function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] d);
      crc_step = {c[6:0], 1'b0} ^ (c[7] ? CRC_POLY : 8'h00) ^ d;
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic wrise;
      logic wfall;
      logic rchar;
      logic grise;
      logic pe;
      logic is_rd;
      logic [7:0] ch;
      logic [7:0] oc;
      logic [15:0] fc_inc;
      r_next = r_reg;
      r_next.start = 1'b0;
      r_next.wtake = 1'b0;
      // Bit 0 of each chain is the first flop, read only by bit 1
      r_next.wclk_s = {r_reg.wclk_s[1:0], transport_write_clock_i};
      r_next.rds_s = {r_reg.rds_s[1:0], rd_strobe_i};
      r_next.gap_s = {r_reg.gap_s[1:0], gap_detect_i};
      r_next.rch_s1 = rd_char_i;
      r_next.rch_s2 = r_reg.rch_s1;
      wrise = r_reg.wclk_s[1] & ~r_reg.wclk_s[2];
      wfall = ~r_reg.wclk_s[1] & r_reg.wclk_s[2];
      rchar = r_reg.rds_s[1] & ~r_reg.rds_s[2];
      grise = r_reg.gap_s[1] & ~r_reg.gap_s[2];
      ch = r_reg.rch_s2[7:0];
      pe = (r_reg.tc[5:3] == DEN_PE);
      oc = r_reg.half ? r_reg.cur[15:8] : r_reg.cur[7:0];
      fc_inc = r_reg.fc + 16'h0001;
      is_rd = (link.fn_code == FN_RD_FWD) || (link.fn_code == FN_RD_REV) ||
         (link.fn_code == FN_WCHK_FWD) || (link.fn_code == FN_WCHK_REV);
      if (link.fc_wr) begin
         r_next.fc = link.fc_data;
      end
      if (link.r_take) begin
         r_next.ravail = 1'b0;
      end
      unique case (r_reg.st)
         ST_IDLE: begin
            // A refused function shows as a one-cycle end-of-block
            r_next.end_of_block = 1'b0;
            if (link.tc_wr) begin
               r_next.tc = link.tc_data;
            end
            if (link.fn_wr) begin
               r_next.err = 3'h0;
               if (is_rd) begin
                  r_next.fwd = (link.fn_code == FN_RD_FWD) ||
                     (link.fn_code == FN_WCHK_FWD);
                  r_next.rev = (link.fn_code == FN_RD_REV) ||
                     (link.fn_code == FN_WCHK_REV);
                  r_next.bus_occupied = 1'b1;
                  r_next.st = ST_RUN_WAIT;
               end else if (link.fn_code == FN_WRITE &&
                     r_reg.fc != 16'h0000) begin
                  r_next.fwd = 1'b1;
                  r_next.wrt = 1'b1;
                  r_next.bus_occupied = 1'b1;
                  r_next.st = ST_RUN_WAIT;
               end else begin
                  r_next.err[ERR_SEQ] = 1'b1;
                  r_next.end_of_block = 1'b1;
               end
            end
         end
         ST_RUN_WAIT: begin
            if (link.run) begin
               r_next.start = 1'b1;
               r_next.crc = 8'h00;
               r_next.lrc = 8'h00;
               r_next.half = 1'b0;
               r_next.cnt = 7'h00;
               r_next.nfull = 1'b0;
               r_next.ph = r_reg.rev ? PH_SKIP : PH_DATA;
               if (r_reg.wrt) begin
                  r_next.cur = link.w_data[15:0];
                  r_next.wtake = 1'b1;
                  r_next.fetch = r_reg.fc + WORD_CHARS;
               end
               r_next.st = ST_XFER;
            end
         end
         ST_XFER: begin
            if (!r_reg.wrt && rchar) begin
               unique case (r_reg.ph)
                  PH_SKIP: r_next.ph = PH_CRC;
                  PH_CRC: begin
                     r_next.chk = ch;
                     if (r_reg.fwd && ch != r_reg.crc) begin
                        r_next.err[ERR_CRC] = 1'b1;
                     end
                     r_next.ph = r_reg.fwd ? PH_LRC : PH_DATA;
                  end
                  PH_LRC: begin
                     if (ch != r_reg.lrc) begin
                        r_next.err[ERR_LRC] = 1'b1;
                     end
                     r_next.end_of_block = 1'b1;
                     r_next.st = ST_GAP;
                  end
                  PH_DATA: begin
                     if (ch == 8'h00) begin
                        if (r_reg.half) begin
                           r_next.rword = {10'h000, r_reg.asm_c};
                           r_next.ravail = 1'b1;
                           r_next.half = 1'b0;
                        end
                        if (r_reg.fwd) begin
                           r_next.ph = PH_CRC;
                        end else begin
                           r_next.end_of_block = 1'b1;
                           r_next.st = ST_GAP;
                        end
                     end else begin
                        r_next.crc = crc_step(r_reg.crc, ch);
                        r_next.lrc = r_reg.lrc ^ ch;
                        r_next.half = ~r_reg.half;
                        r_next.asm_c = ch;
                        if (r_reg.half) begin
                           r_next.rword = {2'h0, ch, r_reg.asm_c};
                           r_next.ravail = 1'b1;
                           if (r_reg.ravail && !link.r_take) begin
                              r_next.err[ERR_SEQ] = 1'b1;
                           end
                        end
                     end
                  end
               endcase
            end else if (r_reg.wrt && wrise) begin
               if (pe && r_reg.cnt <= PRE_ZEROS) begin
                  r_next.wchar = (r_reg.cnt == PRE_ZEROS) ?
                     CHAR_ONES : 9'h000;
                  r_next.cnt = r_reg.cnt + 7'h01;
               end else begin
                  r_next.wchar = {~^oc, oc};
                  r_next.fc = fc_inc;
                  r_next.crc = crc_step(r_reg.crc, oc);
                  r_next.lrc = r_reg.lrc ^ oc;
                  r_next.half = ~r_reg.half;
                  if (r_reg.half) begin
                     r_next.cur = r_reg.nxt;
                     r_next.nfull = 1'b0;
                     if (!r_reg.nfull && fc_inc != 16'h0000) begin
                        r_next.err[ERR_SEQ] = 1'b1;
                     end
                  end
                  if (fc_inc == 16'h0000) begin
                     r_next.cnt = 7'h00;
                     r_next.end_of_block = ~pe;
                     r_next.st = ST_TAIL;
                  end
               end
            end
            // Keep fetching while fetched words cover too few characters
            if (link.w_req && link.w_avail && !r_reg.wtake) begin
               r_next.nxt = link.w_data[15:0];
               r_next.nfull = 1'b1;
               r_next.wtake = 1'b1;
               r_next.fetch = r_reg.fetch + WORD_CHARS;
            end
         end
         ST_TAIL: begin
            if (wrise) begin
               r_next.cnt = r_reg.cnt + 7'h01;
               if (pe) begin
                  r_next.wchar = (r_reg.cnt == 7'h00) ?
                     CHAR_ONES : 9'h000;
                  if (r_reg.cnt == PRE_ZEROS) begin
                     r_next.end_of_block = 1'b1;
                     r_next.st = ST_GAP;
                  end
               end else if (r_reg.cnt == 7'h00) begin
                  r_next.wchar = {~^r_reg.crc, r_reg.crc};
               end else begin
                  r_next.wchar = {~^r_reg.lrc, r_reg.lrc};
                  r_next.st = ST_GAP;
               end
            end
         end
         ST_GAP: begin
            if (grise) begin
               r_next.fwd = 1'b0;
               r_next.rev = 1'b0;
               r_next.wrt = 1'b0;
               r_next.bus_occupied = 1'b0;
               r_next.end_of_block = 1'b0;
               r_next.st = ST_IDLE;
            end
         end
         default: r_next.st = ST_IDLE;
      endcase
      // Second half of each phase-encoded cell but the last postamble one is the complement
      if (r_reg.wrt && pe && wfall &&
            (r_reg.st == ST_XFER || r_reg.st == ST_TAIL)) begin
         r_next.wchar = ~r_reg.wchar;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign slave_sel_o = r_reg.tc[2:0];
   assign density_select_bits_o = r_reg.tc[5:3];
   assign forward_motion_line_o = r_reg.fwd;
   assign reverse_motion_line_o = r_reg.rev;
   assign write_line_o = r_reg.wrt;
   assign slave_start_o = r_reg.start;
   assign wr_char_o = r_reg.wchar;
   assign link.bus_occupied = r_reg.bus_occupied;
   assign link.end_of_block = r_reg.end_of_block;
   assign link.drive_ready = (r_reg.st == ST_IDLE);
   assign link.err = r_reg.err;
   assign link.check = r_reg.chk;
   assign link.r_data = r_reg.rword;
   assign link.r_avail = r_reg.ravail;
   assign link.w_take = r_reg.wtake;
   assign link.w_req = r_reg.wrt && r_reg.st == ST_XFER &&
      r_reg.fetch[15] && !r_reg.nfull;
endmodule

// *** core/tape_controller.sv ***
// Drive-bus controller end with an AXI4-Lite register slave
`timescale 1ns/1ps
module tape_controller
   import tape_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   tape_link_if.ctl link,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq_o
);
   typedef struct packed {
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic w_ok;
      logic [31:0] w_data;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [5:0] fn;
      logic ie;
      logic rd_mode;
      logic wr_mode;
      logic run;
      logic done;
      logic ebl_q;
      logic [5:0] tc;
      logic [15:0] fc;
      logic [17:0] tx;
      logic tx_full;
      logic [17:0] rx;
      logic rx_full;
      logic fn_wr;
      logic tc_wr;
      logic fc_wr;
      logic rtake;
   } ctl_s;

   ctl_s r_reg;
   ctl_s r_next;

   always_comb begin
      logic [31:0] rd;
      logic [5:0] code;
      r_next = r_reg;
      r_next.fn_wr = 1'b0;
      r_next.tc_wr = 1'b0;
      r_next.fc_wr = 1'b0;
      r_next.rtake = 1'b0;
      r_next.ebl_q = link.end_of_block;
      rd = RESET_WORD;
      code = r_reg.w_data[5:0];
      // ------------------------------------------------------------
      // Register writes, applied once both address and data are in
      // ------------------------------------------------------------
      if (s_axi_awvalid && s_axi_awready) begin
         r_next.aw_full = 1'b1;
         r_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         r_next.w_full = 1'b1;
         r_next.w_data = s_axi_wdata;
         // Partial-word writes are answered and raise no strobe, but still load the TC and FC registers
         r_next.w_ok = &s_axi_wstrb;
      end
      if (r_reg.bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
      end
      if (link.w_take) begin
         r_next.tx_full = 1'b0;
      end
      if (r_reg.aw_full && r_reg.w_full && !r_reg.bvalid) begin
         r_next.aw_full = 1'b0;
         r_next.w_full = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = RESP_OKAY;
         unique case (r_reg.aw_addr)
            OFS_CS1: begin
               if (r_reg.w_ok) begin
                  r_next.fn = code;
                  r_next.ie = r_reg.w_data[CS1_IE_BIT];
                  r_next.fn_wr = 1'b1;
                  r_next.done = 1'b0;
                  r_next.rd_mode = (code == FN_RD_FWD) ||
                     (code == FN_RD_REV) || (code == FN_WCHK_FWD) ||
                     (code == FN_WCHK_REV);
                  r_next.wr_mode = (code == FN_WRITE);
               end
            end
            OFS_CS2: r_next.bresp = RESP_OKAY;
            OFS_TC: begin
               r_next.tc = r_reg.w_data[5:0];
               r_next.tc_wr = r_reg.w_ok;
            end
            OFS_FC: begin
               r_next.fc = r_reg.w_data[15:0];
               r_next.fc_wr = r_reg.w_ok;
            end
            OFS_DATA: begin
               if (r_reg.w_ok) begin
                  r_next.tx = r_reg.w_data[17:0];
                  r_next.tx_full = 1'b1;
               end
            end
            default: r_next.bresp = RESP_SLVERR;
         endcase
      end
      // ------------------------------------------------------------
      // Register reads
      // ------------------------------------------------------------
      if (r_reg.rvalid && s_axi_rready) begin
         r_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         r_next.rvalid = 1'b1;
         r_next.rresp = RESP_OKAY;
         unique case (s_axi_araddr)
            OFS_CS1: begin
               rd[5:0] = r_reg.fn;
               rd[CS1_IE_BIT] = r_reg.ie;
               rd[CS1_DONE_BIT] = r_reg.done;
               rd[CS1_RUN_BIT] = r_reg.run;
            end
            OFS_CS2: begin
               rd[CS2_OCC_BIT] = link.bus_occupied;
               rd[CS2_EBL_BIT] = link.end_of_block;
               rd[CS2_DRY_BIT] = link.drive_ready;
               rd[CS2_ERR_LSB +: 3] = link.err;
               rd[CS2_WREQ_BIT] = link.w_req;
               rd[CS2_TXF_BIT] = r_reg.tx_full;
               rd[CS2_RXF_BIT] = r_reg.rx_full;
               rd[CS2_CHK_LSB +: 8] = link.check;
            end
            OFS_TC: rd[5:0] = r_reg.tc;
            OFS_FC: rd[15:0] = r_reg.fc;
            OFS_DATA: begin
               rd[17:0] = r_reg.rx;
               r_next.rx_full = 1'b0;
            end
            default: r_next.rresp = RESP_SLVERR;
         endcase
         r_next.rdata = rd;
      end
      // ------------------------------------------------------------
      // Drive bus sequencing
      // ------------------------------------------------------------
      if (link.r_avail && !r_reg.rx_full && !r_reg.rtake) begin
         r_next.rx = link.r_data;
         r_next.rx_full = 1'b1;
         r_next.rtake = 1'b1;
      end
      if (r_reg.fn_wr && r_reg.rd_mode) begin
         r_next.run = 1'b1;
      end
      if (r_reg.wr_mode && r_reg.tx_full && link.bus_occupied) begin
         r_next.run = 1'b1;
      end
      // Block end beats a same-cycle function write
      if (r_reg.ebl_q && !link.end_of_block) begin
         r_next.done = 1'b1;
         r_next.run = 1'b0;
         r_next.rd_mode = 1'b0;
         r_next.wr_mode = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign s_axi_awready = !r_reg.aw_full && !r_reg.bvalid;
   assign s_axi_wready = !r_reg.w_full && !r_reg.bvalid;
   assign s_axi_bresp = r_reg.bresp;
   assign s_axi_bvalid = r_reg.bvalid;
   assign s_axi_arready = !r_reg.rvalid;
   assign s_axi_rdata = r_reg.rdata;
   assign s_axi_rresp = r_reg.rresp;
   assign s_axi_rvalid = r_reg.rvalid;
   assign irq_o = r_reg.done && r_reg.ie;
   assign link.fn_wr = r_reg.fn_wr;
   assign link.fn_code = r_reg.fn;
   assign link.tc_wr = r_reg.tc_wr;
   assign link.tc_data = r_reg.tc;
   assign link.fc_wr = r_reg.fc_wr;
   assign link.fc_data = r_reg.fc;
   assign link.run = r_reg.run;
   assign link.w_data = r_reg.tx;
   assign link.w_avail = r_reg.tx_full;
   assign link.r_take = r_reg.rtake;
endmodule

// *** sim/tape_link_chk.sv ***
// Checker of the drive-bus handshake between formatter and controller
`timescale 1ns/1ps
module tape_link_chk
   import tape_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic fn_wr,
   input wire logic [5:0] fn_code,
   input wire logic run,
   input wire logic bus_occupied,
   input wire logic end_of_block,
   input wire logic drive_ready,
   input wire logic [2:0] err,
   input wire logic r_avail,
   input wire logic r_take,
   input wire logic w_avail,
   input wire logic w_take
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic rd_fn;
   logic bad_fn;
   assign rd_fn = fn_wr && drive_ready && fn_code inside {FN_RD_FWD, FN_RD_REV,
      FN_WCHK_FWD, FN_WCHK_REV};
   assign bad_fn = fn_wr && drive_ready && !(fn_code inside {FN_RD_FWD, FN_RD_REV,
      FN_WCHK_FWD, FN_WCHK_REV, FN_WRITE});
   a_rd_occ: assert property (rd_fn |=> bus_occupied && !end_of_block)
      else $error("bus not held after read code");
   a_bad_fn: assert property (bad_fn |=> err[2] && end_of_block && !bus_occupied ##1 !end_of_block)
      else $error("bad code not refused");
   a_run_rd: assert property (rd_fn |-> ##2 run)
      else $error("run late after read code");
   a_occ_busy: assert property (bus_occupied |-> !drive_ready)
      else $error("ready while bus held");
   a_ebl_hold: assert property ($rose(end_of_block) && bus_occupied |=> end_of_block)
      else $error("block end dropped early");
   a_dry_end: assert property ($fell(end_of_block) |-> drive_ready && !bus_occupied)
      else $error("block end fell without ready");
   a_take_ok: assert property (r_take |-> r_avail ##2 !r_avail)
      else $error("word strobe out of step");
   a_first_wd: assert property ($rose(run) && w_avail |-> ##[1:3] w_take)
      else $error("first word not latched");
endmodule

// *** sim/tb_top.sv ***
// Testbench of formatter and controller joined across the drive bus
`timescale 1ns/1ps
module tb_top
   import tape_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq_o, slave_start_o;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [2:0] slave_sel_o, density_select_bits_o;
   logic forward_motion_line_o, reverse_motion_line_o, write_line_o;
   logic [8:0] wr_char_o, rd_char_i = 9'h000;
   logic rd_strobe_i = 1'b0, transport_write_clock_i = 1'b0;
   logic gap_detect_i = 1'b0;
   int n_fail = 0;
   int checked = 0;
   always #20 core_clk_i = ~core_clk_i;
   tape_link_if lk();
   tape_formatter u_tape_formatter(.core_clk_i, .rst_n_i, .link(lk),
      .slave_sel_o, .density_select_bits_o, .forward_motion_line_o,
      .reverse_motion_line_o, .write_line_o, .slave_start_o, .wr_char_o,
      .rd_char_i, .rd_strobe_i, .transport_write_clock_i, .gap_detect_i);
   tape_controller u_tape_controller(.core_clk_i, .rst_n_i, .link(lk),
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .irq_o);
   tape_link_chk u_tape_link_chk(.core_clk_i, .rst_n_i, .fn_wr(lk.fn_wr),
      .fn_code(lk.fn_code), .run(lk.run), .bus_occupied(lk.bus_occupied), .end_of_block(lk.end_of_block),
      .drive_ready(lk.drive_ready), .err(lk.err), .r_avail(lk.r_avail),
      .r_take(lk.r_take), .w_avail(lk.w_avail), .w_take(lk.w_take));
   // ----------------------------------------
   // Shared bus and pin tasks
   // ----------------------------------------
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // Handshakes are judged at the rising edge, before the design updates
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge core_clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
   endtask
   task rd(input logic [7:0] a);
      @(posedge core_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge core_clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         rv = s_axi_rdata;
         rr = s_axi_rresp;
      end while (!s_axi_rvalid);
   endtask
   task ch(input logic [7:0] c);
      rd_char_i <= {1'b0, c};
      cyc(4);
      rd_strobe_i <= 1'b1;
      cyc(4);
      rd_strobe_i <= 1'b0;
      cyc(4);
   endtask
   task gap();
      gap_detect_i <= 1'b1;
      cyc(6);
      gap_detect_i <= 1'b0;
      cyc(6);
   endtask
   task wc();
      transport_write_clock_i <= 1'b1;
      cyc(4);
      transport_write_clock_i <= 1'b0;
      cyc(4);
   endtask
   task t_rd_fwd();
      wr(OFS_TC, 32'h0000_001D);
      wr(OFS_CS1, 32'h0000_0079);
      cyc(6);
      chk({forward_motion_line_o, reverse_motion_line_o,
         density_select_bits_o, slave_sel_o}, {2'b10, 6'h1D});
      ch(8'h12);
      ch(8'h34);
      ch(8'h00);
      ch(8'hC3);
      ch(8'h26);
      rd(OFS_DATA);
      chk(rv, 32'h0000_3412);
      rd(OFS_CS2);
      chk({rv[23:16], rv[4], rv[1]}, {8'hC3, 1'b0, 1'b1});
      gap();
      rd(OFS_CS2);
      chk(rv[2:0], 3'b100);
      rd(OFS_CS1);
      chk({rv[7], irq_o}, 2'b11);
   endtask
   task t_rd_rev();
      wr(OFS_CS1, 32'h0000_003F);
      cyc(6);
      chk({forward_motion_line_o, reverse_motion_line_o}, 2'b01);
      ch(8'h55);
      ch(8'hA5);
      ch(8'h12);
      ch(8'h34);
      ch(8'h00);
      rd(OFS_DATA);
      rd(OFS_CS2);
      chk({rv[23:16], rv[5:3]}, {8'hA5, 3'h0});
      gap();
      chk(irq_o, 1'b0);
   endtask
   task t_wr_nrz();
      wr(OFS_TC, 32'h0000_0002);
      wr(OFS_FC, 32'h0000_FFFE);
      wr(OFS_DATA, 32'h0000_CDAB);
      wr(OFS_CS1, 32'h0000_0031);
      cyc(8);
      chk({forward_motion_line_o, write_line_o}, 2'b11);
      wc();
      chk(wr_char_o, {~^8'hAB, 8'hAB});
      wc();
      chk(wr_char_o, {~^8'hCD, 8'hCD});
      rd(OFS_CS2);
      chk(rv[1], 1'b1);
      wc();
      wc();
      gap();
      rd(OFS_CS2);
      chk(rv[2:0], 3'b100);
   endtask
   task t_bad();
      wr(OFS_CS1, 32'h0000_0001);
      cyc(4);
      rd(OFS_CS2);
      chk({rv[5], rv[0]}, 2'b10);
      rd(8'hFC);
      chk(rr, RESP_SLVERR);
   endtask
   task final_report();
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Whole run is a few hundred cycles; this cuts a hang short
   initial begin
      #2_000_000;
      n_fail++;
      final_report();
   end
   initial begin
      cyc(20);
      rst_n_i <= 1'b1;
      rd(OFS_CS2);
      chk(rv[8:0], 9'h004);
      t_rd_fwd();
      t_rd_rev();
      t_wr_nrz();
      t_bad();
      final_report();
   end
endmodule
